// ### hdl/mmd_memory_map.sv
// Operation
// R1: Vector slots fill ROM 0-F; fetch there after events.
// R2: Short call targets only ROM 0-3F.
// R3: Pattern fetch reads any ROM up to 0FFF.
// R4: Program space top depends on size variant.
// R5: RAM has 384 or 512 four-bit digits.
// R6: Lowest 64 RAM addresses are register overlay.
// R7: Addresses 0-3 are bit-op-only interrupt bits.
// R8: 004-01F and 024-03F decode to special registers.
// R9: Software never bit-ops special registers.
// R10: Addresses 020-023 are bit-op-only flags.
// R11: Sixteen memory registers at 040-04F for transfers.
// R12: Calls and interrupts save PC, status, carry.
// R13: Sixteen levels, four digits each.
// R14: Both returns restore PC; interrupt return restores flags.
// R15: Unused stack digits act as ordinary data RAM.
// R16: Pointer resets 3FF, moves by four, top bits ones.
//
// Purpose: Memory map decode and call stack engine for a 4-bit core.
// Assumes: Core gives one request at a time and waits for done.
// Notes:   Data RAM and stack share one digit array.
module mmd_memory_map
    import mmd_pkg::*;
#(
    parameter logic [1:0] VARIANT = 2'h0
)(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [ROM_AW-1:0] fetchAddr,
    input  wire logic              fetchValid,
    input  wire logic              shortCall,
    input  wire logic              patternFetch,
    input  wire logic              vectorReq,
    input  wire logic [3:0]        vectorIdx,
    input  wire logic [RAM_AW-1:0] ramAddr,
    input  wire logic              ramWrite,
    input  wire logic              ramRead,
    input  wire logic [3:0]        ramWdata,
    input  wire logic              bitOp,
    input  wire logic              memregOp,
    input  wire logic              pushReq,
    input  wire logic              popReq,
    input  wire logic              popFlags,
    input  wire logic [ROM_AW-1:0] pushPc,
    input  wire logic              pushStatus,
    input  wire logic              pushCarry,
    input  wire logic              spReset,
    output logic [ROM_AW-1:0]      romAddr_reg,
    output logic                   romOk_reg,
    output logic [3:0]             ramRdata_reg,
    output mmd_region_t            region_reg,
    output logic                   accessErr_reg,
    output logic [RAM_AW-1:0]      stackPointer_reg,
    output logic [ROM_AW-1:0]      popPc_reg,
    output logic                   statusFlag_reg,
    output logic                   carryFlag_reg,
    output logic                   stackDone_reg
);
    localparam bit LARGE = (VARIANT == 2'h3);
    localparam int RAM_DEPTH = 1 << RAM_AW;
    localparam logic [13:0] ROM_TOP = (VARIANT == 2'h0) ? ROM_TOP_V0 :
                                      (VARIANT == 2'h1) ? ROM_TOP_V1 :
                                      (VARIANT == 2'h2) ? ROM_TOP_V2 : ROM_TOP_V3;
    // A stack that is not sixteen levels deep would break the pointer wrap.
    if (STACK_DIGITS / LEVEL_DIGITS != 16)
    begin : g_geomCheck
        $error("Stack geometry does not give sixteen levels.");
    end

    // The array is sized to the full space so the stack at 3C0 needs no remap.
    logic [3:0] ram [RAM_DEPTH];
    mmd_region_t decRegion;
    logic        decStack;

    mmd_ram_decode #(.LARGE(LARGE)) uDecode (
        .addr    (ramAddr),
        .region  (decRegion),
        .isStack (decStack)
    );

    // ROM side.
    logic [ROM_AW-1:0] romAddr_next;
    logic              romOk_next;
    always_comb
    begin
        romAddr_next = romAddr_reg;
        romOk_next   = romOk_reg;
        if (vectorReq)
        begin
            romAddr_next = {10'h000, vectorIdx}; // R1
            romOk_next   = 1'b1;
        end
        else if (fetchValid)
        begin
            romAddr_next = fetchAddr;
            if (shortCall)
                romOk_next = (fetchAddr <= ROM_ZPAGE_TOP); // R2
            else if (patternFetch)
                romOk_next = (fetchAddr <= ROM_PATTERN_TOP); // R3
            else
                romOk_next = (fetchAddr <= ROM_TOP); // R4
        end
    end

    // RAM access classification.
    logic       accessErr_next;
    logic       cellOk;
    logic [3:0] ramRdata_next;
    always_comb
    begin
        accessErr_next = 1'b0;
        cellOk         = 1'b0;
        case (decRegion)
            MMD_REG_ICB, MMD_REG_FLAG: accessErr_next = !bitOp; // R7 R10
            MMD_REG_SFR:               accessErr_next = bitOp; // R8 R9
            MMD_REG_MR:
            begin
                accessErr_next = !memregOp && bitOp; // R11
                cellOk         = !accessErr_next;
            end
            MMD_REG_DATA:
            begin
                // Live stack levels belong to the engine; free ones are data.
                accessErr_next = decStack && (ramAddr > stackPointer_reg);
                cellOk         = !accessErr_next; // R15
            end
            default:                   accessErr_next = 1'b1;
        endcase
        if (!(ramRead || ramWrite))
            accessErr_next = 1'b0;
        ramRdata_next = ramRdata_reg;
        if (ramRead && cellOk)
            ramRdata_next = ram[ramAddr];
    end

    // Stack engine.
    mmd_state_t         state_reg, state_next;
    logic [RAM_AW-1:0]  sp_next;
    logic [ROM_AW-1:0]  popPc_next;
    logic               status_next, carry_next, done_next;
    logic               wrEn;
    logic [RAM_AW-1:0]  wrAddr;
    logic [3:0]         wrData;
    logic [RAM_AW-1:0]  lvl;
    assign lvl = stackPointer_reg - 10'h003;
    always_comb
    begin
        state_next  = state_reg;
        sp_next     = stackPointer_reg;
        popPc_next  = popPc_reg;
        status_next = statusFlag_reg;
        carry_next  = carryFlag_reg;
        done_next   = 1'b0;
        wrEn        = ramWrite && cellOk && (state_reg == MMD_IDLE);
        wrAddr      = ramAddr;
        wrData      = ramWdata;
        case (state_reg)
            MMD_IDLE:
            begin
                if (spReset)
                    sp_next = SP_RESET; // R16
                else if (pushReq)
                    state_next = MMD_PUSH1;
                else if (popReq)
                    state_next = MMD_POP1;
            end
            MMD_PUSH1:
            begin
                // Level layout: low PC, mid PC, high PC, then status, carry and PC top bits in one digit.
                wrEn       = 1'b1;
                wrAddr     = lvl;
                wrData     = pushPc[3:0]; // R12
                state_next = MMD_PUSH2;
            end
            MMD_PUSH2:
            begin
                wrEn       = 1'b1;
                wrAddr     = stackPointer_reg;
                wrData     = {pushStatus, pushCarry, pushPc[13:12]}; // R12
                sp_next    = {SP_FIXED_HI, 6'(stackPointer_reg[5:0] - SP_STEP[5:0])}; // R16 R13
                done_next  = 1'b1;
                state_next = MMD_IDLE;
            end
            MMD_POP1:
            begin
                sp_next    = {SP_FIXED_HI, 6'(stackPointer_reg[5:0] + SP_STEP[5:0])}; // R16
                state_next = MMD_POP2;
            end
            MMD_POP2:
            begin
                popPc_next = {ram[stackPointer_reg][1:0], ram[stackPointer_reg - 10'h001],
                              ram[stackPointer_reg - 10'h002], ram[lvl]}; // R14
                if (popFlags)
                begin
                    status_next = ram[stackPointer_reg][3]; // R14
                    carry_next  = ram[stackPointer_reg][2];
                end
                done_next  = 1'b1;
                state_next = MMD_IDLE;
            end
            default: state_next = MMD_IDLE;
        endcase
    end

    // Middle PC digits go in the push cycles' spare port slot.
    logic [RAM_AW-1:0] wr2Addr;
    logic [3:0]        wr2Data;
    logic              wr2En;
    always_comb
    begin
        wr2En   = (state_reg == MMD_PUSH1) || (state_reg == MMD_PUSH2);
        wr2Addr = (state_reg == MMD_PUSH1) ? lvl + 10'h001 : stackPointer_reg - 10'h001;
        wr2Data = (state_reg == MMD_PUSH1) ? pushPc[7:4] : pushPc[11:8];
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg        <= MMD_IDLE;
            stackPointer_reg <= SP_RESET; // R16
            romAddr_reg      <= '0; // R1
            romOk_reg        <= 1'b1;
            ramRdata_reg     <= '0;
            region_reg       <= MMD_REG_NONE;
            accessErr_reg    <= 1'b0;
            popPc_reg        <= '0;
            statusFlag_reg   <= ST_RESET[0];
            carryFlag_reg    <= 1'b0;
            stackDone_reg    <= 1'b0;
        end
        else
        begin
            state_reg        <= state_next;
            stackPointer_reg <= sp_next;
            romAddr_reg      <= romAddr_next;
            romOk_reg        <= romOk_next;
            ramRdata_reg     <= ramRdata_next;
            region_reg       <= decRegion;
            accessErr_reg    <= accessErr_next;
            popPc_reg        <= popPc_next;
            statusFlag_reg   <= status_next;
            carryFlag_reg    <= carry_next;
            stackDone_reg    <= done_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (wrEn)
            ram[wrAddr] <= wrData;
        if (wr2En)
            ram[wr2Addr] <= wr2Data;
    end

    sequence s_push;
        (state_reg == MMD_IDLE) && pushReq && !spReset ##1 state_reg == MMD_PUSH1;
    endsequence

    sequence s_pop;
        (state_reg == MMD_IDLE) && popReq && !pushReq && !spReset;
    endsequence

    a_sp_push_step: assert property (@(posedge clk) disable iff (srst) // R16
        s_push |=> ##1 stackPointer_reg[5:0] == $past(stackPointer_reg[5:0], 2) - SP_STEP[5:0])
        else $error("Push did not lower the pointer by four.");
    a_sp_high_bits: assert property (@(posedge clk) disable iff (srst) // R16
        stackPointer_reg[9:6] == SP_FIXED_HI)
        else $error("Pointer high bits are not all ones.");
    a_vector_fetch: assert property (@(posedge clk) disable iff (srst) // R1
        vectorReq |=> romAddr_reg <= ROM_VEC_TOP && romOk_reg)
        else $error("Vector fetch left the vector area.");
    a_short_call: assert property (@(posedge clk) disable iff (srst) // R2
        fetchValid && !vectorReq && shortCall && fetchAddr > ROM_ZPAGE_TOP |=> !romOk_reg)
        else $error("Short call allowed outside zero page.");
    a_pattern_range: assert property (@(posedge clk) disable iff (srst) // R3
        fetchValid && !vectorReq && !shortCall && patternFetch |=>
        romOk_reg == (romAddr_reg <= ROM_PATTERN_TOP))
        else $error("Pattern fetch range wrong.");
    a_sfr_bitop: assert property (@(posedge clk) disable iff (srst) // R8
        ramWrite && bitOp && decRegion == MMD_REG_SFR |=> accessErr_reg)
        else $error("Bit op on special register not flagged.");
    a_icb_plain: assert property (@(posedge clk) disable iff (srst) // R7
        ramRead && !bitOp && decRegion == MMD_REG_ICB |=> accessErr_reg)
        else $error("Plain access to interrupt bits not flagged.");
    // Done rises after the third edge: enter POP1, pointer step, then flag sample and pulse together.
    a_pop_done: assert property (@(posedge clk) disable iff (srst) // R14
        s_pop |-> ##3 stackDone_reg)
        else $error("Pop did not finish in three cycles.");
    a_plain_ret_flags: assert property (@(posedge clk) disable iff (srst) // R14
        state_reg == MMD_POP2 && !popFlags |=> $stable(statusFlag_reg) && $stable(carryFlag_reg))
        else $error("Plain return changed the flags.");
endmodule

// ### hdl/mmd_ram_decode.sv
// Purpose: Classifies a RAM digit address into its region.
// Assumes: Pure combinational decode, no state.
// Notes:   Stack area counts as data; the top tracks occupancy.
module mmd_ram_decode
    import mmd_pkg::*;
#(
    parameter bit LARGE = 1'b0
)(
    input  wire logic [RAM_AW-1:0] addr,
    output mmd_region_t            region,
    output logic                   isStack
);
    always_comb
    begin
        isStack = (addr >= RAM_STACK_BASE);
        if (addr <= RAM_ICB_TOP)
            region = MMD_REG_ICB; // R7
        else if (addr <= RAM_SFR1_TOP)
            region = MMD_REG_SFR; // R8
        else if (addr <= RAM_FLAG_TOP)
            region = MMD_REG_FLAG; // R10
        else if (addr <= RAM_REGAREA_TOP)
            region = MMD_REG_SFR; // R6
        else if (addr <= RAM_MR_TOP)
            region = MMD_REG_MR; // R11
        else if (addr <= (LARGE ? RAM_DATA_TOP_L : RAM_DATA_TOP_S))
            region = MMD_REG_DATA; // R5
        else if (isStack)
            region = MMD_REG_DATA; // R15
        else
            region = MMD_REG_NONE;
    end
endmodule

// ### shared/mmd_pkg.sv
// Purpose: Constants and types for the memory map decoder.
// Assumes: 10-bit RAM digit addresses, 14-bit ROM word addresses.
// Notes:   Addresses are in digits for RAM and in words for ROM.
package mmd_pkg;
    localparam int ROM_AW = 14;
    localparam int RAM_AW = 10;
    localparam logic [13:0] ROM_VEC_TOP     = 14'h000F;
    localparam logic [13:0] ROM_ZPAGE_TOP   = 14'h003F;
    localparam logic [13:0] ROM_PATTERN_TOP = 14'h0FFF;
    localparam logic [13:0] ROM_TOP_V0      = 14'h0FFF;
    localparam logic [13:0] ROM_TOP_V1      = 14'h17FF;
    localparam logic [13:0] ROM_TOP_V2      = 14'h1FFF;
    localparam logic [13:0] ROM_TOP_V3      = 14'h3FFF;
    localparam logic [9:0]  RAM_ICB_TOP     = 10'h003;
    localparam logic [9:0]  RAM_SFR1_TOP    = 10'h01F;
    localparam logic [9:0]  RAM_FLAG_BASE   = 10'h020;
    localparam logic [9:0]  RAM_FLAG_TOP    = 10'h023;
    localparam logic [9:0]  RAM_SFR2_BASE   = 10'h024;
    localparam logic [9:0]  RAM_REGAREA_TOP = 10'h03F;
    localparam logic [9:0]  RAM_MR_BASE     = 10'h040;
    localparam logic [9:0]  RAM_MR_TOP      = 10'h04F;
    localparam logic [9:0]  RAM_DATA_BASE   = 10'h050;
    localparam logic [9:0]  RAM_DATA_TOP_S  = 10'h17F;
    localparam logic [9:0]  RAM_DATA_TOP_L  = 10'h1FF;
    localparam logic [9:0]  RAM_STACK_BASE  = 10'h3C0;
    localparam logic [9:0]  SP_RESET        = 10'h3FF;
    localparam logic [9:0]  SP_STEP         = 10'h004;
    localparam logic [3:0]  SP_FIXED_HI     = 4'hF;
    localparam logic [2:0]  ST_RESET        = 3'h1;
    localparam int          RAM_DIGITS_S    = 384;
    localparam int          RAM_DIGITS_L    = 512;
    localparam int          STACK_DIGITS    = 64;
    localparam int          LEVEL_DIGITS    = 4;

    typedef enum logic [5:0] {
        MMD_REG_NONE = 6'h01,
        MMD_REG_ICB  = 6'h02,
        MMD_REG_SFR  = 6'h04,
        MMD_REG_FLAG = 6'h08,
        MMD_REG_MR   = 6'h10,
        MMD_REG_DATA = 6'h20
    } mmd_region_t;

    typedef enum logic [4:0] {
        MMD_IDLE  = 5'h01,
        MMD_PUSH1 = 5'h02,
        MMD_PUSH2 = 5'h04,
        MMD_POP1  = 5'h08,
        MMD_POP2  = 5'h10
    } mmd_state_t;
endpackage

// ### verification/test_mmd_memory_map.sv
// Purpose: Self-checking bench for the memory map decoder.
// Assumes: VARIANT 1, so the ROM top is 17FF and the RAM has 384 digits.
// Notes:   Expected results wait in a queue until the matching output shows.
module test_mmd_memory_map
    import mmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int kind; logic [31:0] e; logic [31:0] m; int due;} mmd_note_t;
    logic              clk, srst, fetchValid, shortCall, patternFetch, vectorReq;
    logic              ramWrite, ramRead, bitOp, memregOp, pushReq, popReq, popFlags;
    logic              pushStatus, pushCarry, spReset;
    logic [13:0]       fetchAddr, pushPc, romAddr_reg, popPc_reg, ra;
    logic [3:0]        vectorIdx, ramWdata, ramRdata_reg, v;
    logic [9:0]        ramAddr, stackPointer_reg, sp;
    mmd_region_t       region_reg;
    logic              romOk_reg, accessErr_reg, statusFlag_reg, carryFlag_reg;
    logic              stackDone_reg, cSt, cCa;
    logic [31:0]       got;
    logic [15:0]       lifo[$];
    mmd_note_t         notes[$];
    int                n_mismatch, n_checks, cyc, seed;

    mmd_memory_map #(.VARIANT(2'h1)) i_dut (.clk, .srst, .fetchAddr, .fetchValid, .shortCall,
        .patternFetch, .vectorReq, .vectorIdx, .ramAddr, .ramWrite, .ramRead, .ramWdata,
        .bitOp, .memregOp, .pushReq, .popReq, .popFlags, .pushPc, .pushStatus, .pushCarry,
        .spReset, .romAddr_reg, .romOk_reg, .ramRdata_reg, .region_reg, .accessErr_reg,
        .stackPointer_reg, .popPc_reg, .statusFlag_reg, .carryFlag_reg, .stackDone_reg);

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
        n_checks++;
        if ((g & m) !== (e & m))
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g & m, e & m);
        end
    endtask

    task automatic note(input int k, input logic [31:0] e, input logic [31:0] m);
        // Driven after this edge, taken at the next, shown at the falling edge after that.
        notes.push_back('{k, e, m, cyc + 2});
    endtask

    // Takes the oldest note; a result of the wrong kind means something went missing.
    task automatic take(input int k, input logic [31:0] g);
        if (notes.size() == 0 || notes[0].kind != k)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, 32'h0);
        end
        else
        begin
            chk(g, notes[0].e, notes[0].m);
            void'(notes.pop_front());
        end
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Watches on the falling edge so that every registered output has settled.
    always @(negedge clk)
    begin
        cyc++;
        if (stackDone_reg === 1'b1)
            take(3, {6'h0, stackPointer_reg, popPc_reg, statusFlag_reg, carryFlag_reg});
        while (notes.size() > 0 && notes[0].kind != 3 && notes[0].due == cyc)
        begin
            case (notes[0].kind)
                0: got = {17'h0, romOk_reg, romAddr_reg};
                1: got = {28'h0, ramRdata_reg};
                default: got = {25'h0, accessErr_reg, region_reg};
            endcase
            take(notes[0].kind, got);
        end
    end

    // Mode 0 program, 1 short call, 2 pattern, 3 vector slot a[3:0].
    task automatic romReq(input logic [13:0] a, input logic [1:0] mode, input logic ok);
        @(posedge clk);
        fetchAddr <= a;
        fetchValid <= (mode != 2'h3);
        shortCall <= (mode == 2'h1);
        patternFetch <= (mode == 2'h2);
        vectorReq <= (mode == 2'h3);
        vectorIdx <= a[3:0];
        note(0, {17'h0, ok, a}, 32'h7FFF);
    endtask

    task automatic ramReq(input logic [9:0] a, input logic wr, input logic rd,
                          input logic [3:0] wd, input logic bo, input logic mr,
                          input logic [6:0] rg, input logic [6:0] m, input logic dchk);
        @(posedge clk);
        ramAddr <= a;
        ramWrite <= wr;
        ramRead <= rd;
        ramWdata <= wd;
        bitOp <= bo;
        memregOp <= mr;
        note(2, {25'h0, rg}, {25'h0, m});
        if (dchk)
            note(1, {28'h0, wd}, 32'hF);
    endtask

    task automatic idle;
        @(posedge clk);
        {fetchValid, shortCall, patternFetch, vectorReq} <= 4'h0;
        {ramWrite, ramRead, bitOp, memregOp} <= 4'h0;
    endtask

    // The bench keeps its own stack; the pointer wraps inside its low six bits.
    task automatic stk(input logic push, input logic fl, input logic [13:0] pc,
                       input logic st, input logic ca);
        logic [15:0] e;
        int          i;
        @(posedge clk);
        pushReq <= push;
        popReq <= !push;
        popFlags <= fl;
        pushPc <= pc;
        pushStatus <= st;
        pushCarry <= ca;
        if (push)
        begin
            sp = {4'hF, sp[5:0] - 6'h04};
            lifo.push_back({st, ca, pc});
            note(3, {6'h0, sp, 16'h0}, {6'h0, 10'h3FF, 16'h0});
        end
        else
        begin
            e = lifo.pop_back();
            sp = {4'hF, sp[5:0] + 6'h04};
            if (fl)
                {cSt, cCa} = e[15:14];
            note(3, {6'h0, sp, e[13:0], cSt, cCa}, 32'hFFFFFFFF);
        end
        @(posedge clk);
        pushReq <= 1'b0;
        popReq <= 1'b0;
        for (i = 0; i < 8; i++)
        begin
            @(negedge clk);
            if (stackDone_reg === 1'b1)
                break;
        end
        if (i == 8)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask

    initial
    begin
        {fetchValid, shortCall, patternFetch, vectorReq, ramWrite, ramRead} = 6'h00;
        {bitOp, memregOp, pushReq, popReq, popFlags, pushStatus, pushCarry, spReset} = 8'h00;
        {fetchAddr, pushPc, vectorIdx, ramWdata, ramAddr} = 46'h0;
        srst = 1'b1;
        seed = 96;
        sp = SP_RESET;
        {cSt, cCa} = 2'h2;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk({6'h0, stackPointer_reg, popPc_reg, statusFlag_reg, carryFlag_reg},
            {6'h0, SP_RESET, 14'h0, 2'h2}, 32'hFFFFFFFF);
        chk({17'h0, romOk_reg, romAddr_reg}, 32'h4000, 32'h7FFF);
        for (int i = 0; i < 16; i++)
            romReq(14'(i), 2'h3, 1'b1);
        romReq(ROM_ZPAGE_TOP, 2'h1, 1'b1);
        romReq(14'h0040, 2'h1, 1'b0);
        romReq(ROM_PATTERN_TOP, 2'h2, 1'b1);
        romReq(14'h1000, 2'h2, 1'b0);
        romReq(ROM_TOP_V1, 2'h0, 1'b1);
        romReq(14'h1800, 2'h0, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            ra = 14'($random(seed)) ^ 14'h2A5A;
            romReq(ra, 2'h0, ra <= ROM_TOP_V1);
        end
        idle();
        ramReq(10'h000, 1'b0, 1'b1, 4'h0, 1'b1, 1'b0, {1'b0, MMD_REG_ICB}, 7'h7F, 1'b0);
        ramReq(10'h003, 1'b0, 1'b1, 4'h0, 1'b0, 1'b0, {1'b1, MMD_REG_ICB}, 7'h7F, 1'b0);
        ramReq(10'h004, 1'b0, 1'b1, 4'h0, 1'b0, 1'b0, {1'b0, MMD_REG_SFR}, 7'h3F, 1'b0);
        ramReq(10'h01F, 1'b0, 1'b1, 4'h0, 1'b0, 1'b0, {1'b0, MMD_REG_SFR}, 7'h3F, 1'b0);
        ramReq(10'h020, 1'b0, 1'b1, 4'h0, 1'b1, 1'b0, {1'b0, MMD_REG_FLAG}, 7'h7F, 1'b0);
        ramReq(10'h023, 1'b0, 1'b1, 4'h0, 1'b1, 1'b0, {1'b0, MMD_REG_FLAG}, 7'h7F, 1'b0);
        ramReq(10'h024, 1'b0, 1'b1, 4'h0, 1'b0, 1'b0, {1'b0, MMD_REG_SFR}, 7'h3F, 1'b0);
        ramReq(10'h03F, 1'b0, 1'b1, 4'h0, 1'b0, 1'b0, {1'b0, MMD_REG_SFR}, 7'h3F, 1'b0);
        ramReq(10'h010, 1'b1, 1'b0, 4'h0, 1'b1, 1'b0, {1'b1, MMD_REG_SFR}, 7'h7F, 1'b0);
        ramReq(10'h04F, 1'b0, 1'b1, 4'h0, 1'b0, 1'b1, {1'b0, MMD_REG_MR}, 7'h7F, 1'b0);
        ramReq(10'h050, 1'b0, 1'b1, 4'h0, 1'b0, 1'b0, {1'b0, MMD_REG_DATA}, 7'h7F, 1'b0);
        ramReq(10'h180, 1'b0, 1'b1, 4'h0, 1'b0, 1'b0, {1'b0, MMD_REG_NONE}, 7'h3F, 1'b0);
        ramReq(10'h3FF, 1'b0, 1'b1, 4'h0, 1'b0, 1'b0, {1'b0, MMD_REG_DATA}, 7'h7F, 1'b0);
        v = 4'($random(seed));
        ramReq(10'h17F, 1'b1, 1'b0, v, 1'b0, 1'b0, {1'b0, MMD_REG_DATA}, 7'h7F, 1'b0);
        ramReq(10'h3C3, 1'b1, 1'b0, ~v, 1'b0, 1'b0, {1'b0, MMD_REG_DATA}, 7'h7F, 1'b0);
        ramReq(10'h040, 1'b1, 1'b0, v ^ 4'h5, 1'b0, 1'b1, {1'b0, MMD_REG_MR}, 7'h7F, 1'b0);
        ramReq(10'h17F, 1'b0, 1'b1, v, 1'b0, 1'b0, {1'b0, MMD_REG_DATA}, 7'h7F, 1'b1);
        ramReq(10'h3C3, 1'b0, 1'b1, ~v, 1'b0, 1'b0, {1'b0, MMD_REG_DATA}, 7'h7F, 1'b1);
        ramReq(10'h040, 1'b0, 1'b1, v ^ 4'h5, 1'b0, 1'b1, {1'b0, MMD_REG_MR}, 7'h7F, 1'b1);
        idle();
        repeat (2) @(posedge clk);
        stk(1'b1, 1'b0, 14'($random(seed)), 1'b0, 1'b1);
        stk(1'b1, 1'b0, 14'($random(seed)), 1'b1, 1'b0);
        ramReq(10'h3FF, 1'b0, 1'b1, 4'h0, 1'b0, 1'b0, {1'b1, MMD_REG_DATA}, 7'h7F, 1'b0);
        idle();
        stk(1'b0, 1'b0, 14'h0, 1'b0, 1'b0);
        stk(1'b0, 1'b1, 14'h0, 1'b0, 1'b0);
        for (int i = 0; i < 16; i++)
            stk(1'b1, 1'b0, 14'($random(seed)), i[0], i[1]);
        for (int i = 0; i < 16; i++)
            stk(1'b0, 1'b1, 14'h0, 1'b0, 1'b0);
        stk(1'b1, 1'b0, 14'($random(seed)), 1'b1, 1'b1);
        @(posedge clk);
        spReset <= 1'b1;
        @(posedge clk);
        spReset <= 1'b0;
        @(negedge clk);
        chk({22'h0, stackPointer_reg}, {22'h0, SP_RESET}, 32'h3FF);
        repeat (3) @(posedge clk);
        if (notes.size() != 0)
            n_mismatch++;
        tally_and_finish();
    end
endmodule
